// ### inc/rtc_map.svh
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH
`define ADR_CTL_ONE   4'h0
`define ADR_CTL_TWO   4'h1
`define ADR_SECONDS   4'h2
`define ADR_MINUTES   4'h3
`define ADR_HOURS     4'h4
`define ADR_DAYS      4'h5
`define ADR_LAST      4'hF
`define C1_TEST_BIT   7
`define C1_STOP_BIT   5
`define C1_GATE_BIT   3
`define C1_RESET      8'h08
`define C2_RESET      5'h00
`define SEC_MAX       7'h59
`define MIN_MAX       7'h59
`define HOUR_MAX      6'h23
`define DAY_FIRST     6'h01
`define DAY_SHORT     6'h30
`define DAY_LONG      6'h31
`define DAY_FEB       6'h28
`define DAY_LEAP      6'h29
`define MON_FEB       5'h02
`define MON_APR       5'h04
`define MON_JUN       5'h06
`define MON_SEP       5'h09
`define MON_NOV       5'h11
`define XTAL_HZ       32768
`endif

// ### inc/rtc_pkg.sv
package rtc_pkg;
    typedef struct packed {
        logic irq_pulse_select;
        logic alarm_flag;
        logic timer_flag;
        logic alarm_irq_enable;
        logic timer_irq_enable;
    } ctl_two_t;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       ptr_load;
        logic [7:0] wdata;
    } reg_req_t;
endpackage

// ### rtl/rtc_core.sv
// Contract
// - stop bit clears divider, halts counting
// - gate bit enables override; default one
// - bit seven selects external clock test
// - pulse select: timer irq level or pulse
// - flag and enable bit positions in control two
// - alarm flag with enable holds irq low
// - reset while oscillator stopped; pointer cleared
// - reset values of control and bit seven
// - unlisted bits keep value across resets
// - override ends reset at once
// - clearing gate cancels override; reset needed
// - gate clear otherwise only blocks entry
// - low supply sets sticky flag in seconds
// - supply flag reads one at start-up
// - seconds BCD tens six-four units three-zero
// - minutes BCD, bit seven unused
// - hours 24h BCD, tens five-four
// - days BCD from 1 to 31
// - February 29 when year divisible by four
// - accesses freeze counting, one pending tick
`timescale 1ns/1ps
`include "rtc_map.svh"
module rtc_core #(
    parameter int DIV_COUNT = `XTAL_HZ
) (
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    input  wire logic              xtal_i,
    input  wire logic              osc_running_i,
    input  wire logic              override_seq_i,
    input  wire logic              supply_low_i,
    input  wire logic              alarm_event_i,
    input  wire logic              timer_event_i,
    input  wire logic              access_i,
    input  wire rtc_pkg::reg_req_t req_i,
    input  wire logic [4:0]        month_bcd_i,
    input  wire logic [7:0]        year_bcd_i,
    output logic [7:0]             rdata_o,
    output logic                   int_n_o,
    output logic                   clock_output_o,
    output logic                   external_clock_test_mode_o,
    output logic                   day_carry_o
);
    logic [7:0]        ctl_one_q, ctl_one_d;
    rtc_pkg::ctl_two_t ctl_two_q, ctl_two_d;
    logic [6:0]        sec_q, sec_d, min_q, min_d;
    logic [5:0]        hour_q, hour_d, day_q, day_d;
    logic              vl_q, vl_d, min7_q, min7_d;
    logic [3:0]        ptr_q, ptr_d;
    logic [15:0]       div_q, div_d;
    logic              xtal_q, pend_q, pend_d, ovr_q, ovr_d;
    logic [7:0]        rdata_d;
    logic              int_n_d, carry_d;
    logic              int_rst, tick, step, leap;
    logic [5:0]        day_max;
    logic [7:0]        rd_mux;

    function automatic logic [6:0] bcd_inc(input logic [6:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[6:4] + 3'h1, 4'h0};
        end else begin
            bcd_inc = {v[6:4], v[3:0] + 4'h1};
        end
    endfunction

    // Internal reset follows the oscillator unless the override bypasses it
    assign int_rst = rst_i | (~osc_running_i & ~ovr_q);
    assign tick = (div_q == 16'(DIV_COUNT - 1)) & ~xtal_q & xtal_i;
    // Counting waits for the access to end; the held tick is serviced then
    assign step = (tick | pend_q) & ~access_i & ~int_rst & ~ctl_one_q[`C1_STOP_BIT];

    always_comb begin
        // Year divisible by four in BCD: even tens with 0/4/8, odd tens with 2/6
        leap = year_bcd_i[4] ? (year_bcd_i[3:0] == 4'h2 || year_bcd_i[3:0] == 4'h6)
                             : (year_bcd_i[1:0] == 2'h0);
        case (month_bcd_i)
            `MON_FEB: day_max = leap ? `DAY_LEAP : `DAY_FEB;
            `MON_APR, `MON_JUN, `MON_SEP, `MON_NOV: day_max = `DAY_SHORT;
            default: day_max = `DAY_LONG;
        endcase
    end

    always_comb begin
        // Unimplemented addresses read back as zero
        case (ptr_q)
            `ADR_CTL_ONE: rd_mux = ctl_one_q;
            `ADR_CTL_TWO: rd_mux = {3'h0, ctl_two_q};
            `ADR_SECONDS: rd_mux = {vl_q, sec_q};
            `ADR_MINUTES: rd_mux = {min7_q, min_q};
            `ADR_HOURS:   rd_mux = {2'h0, hour_q};
            `ADR_DAYS:    rd_mux = {2'h0, day_q};
            default:      rd_mux = 8'h00;
        endcase
    end

    always_comb begin
        ctl_one_d = ctl_one_q;
        ctl_two_d = ctl_two_q;
        sec_d     = sec_q;
        min_d     = min_q;
        hour_d    = hour_q;
        day_d     = day_q;
        vl_d      = vl_q;
        min7_d    = min7_q;
        ptr_d     = ptr_q;
        div_d     = div_q;
        pend_d    = pend_q;
        ovr_d     = ovr_q;
        rdata_d   = rdata_o;
        carry_d   = 1'b0;
        // Stop holds the divider cleared; the crystal output is untouched
        if (ctl_one_q[`C1_STOP_BIT] || int_rst) begin
            div_d = 16'h0000;
        end else if (~xtal_q & xtal_i) begin
            div_d = tick ? 16'h0000 : div_q + 16'h0001;
        end
        if (tick && access_i) begin
            pend_d = 1'b1;
        end else if (step) begin
            pend_d = 1'b0;
        end
        if (step) begin
            sec_d = (sec_q == `SEC_MAX) ? 7'h00 : bcd_inc(sec_q);
            if (sec_q == `SEC_MAX) begin
                min_d = (min_q == `MIN_MAX) ? 7'h00 : bcd_inc(min_q);
                if (min_q == `MIN_MAX) begin
                    hour_d = (hour_q == `HOUR_MAX) ? 6'h00 : 6'(bcd_inc({1'b0, hour_q}));
                    if (hour_q == `HOUR_MAX) begin
                        day_d   = (day_q >= day_max) ? `DAY_FIRST : 6'(bcd_inc({1'b0, day_q}));
                        carry_d = (day_q >= day_max);
                    end
                end
            end
        end
        // Pointer wraps past the last address so burst reads never stall
        if (req_i.ptr_load) begin
            ptr_d = req_i.wdata[3:0];
        end else if (req_i.wr || req_i.rd) begin
            ptr_d = ptr_q + 4'h1;
        end
        if (req_i.rd) begin
            rdata_d = rd_mux;
        end
        if (req_i.wr) begin
            case (ptr_q)
                `ADR_CTL_ONE: begin
                    ctl_one_d = req_i.wdata;
                    if (!req_i.wdata[`C1_GATE_BIT]) begin
                        ovr_d = 1'b0;
                    end
                end
                `ADR_CTL_TWO: ctl_two_d = rtc_pkg::ctl_two_t'(req_i.wdata[4:0]);
                `ADR_SECONDS: begin
                    sec_d = req_i.wdata[6:0];
                    vl_d  = req_i.wdata[7];
                end
                `ADR_MINUTES: begin
                    min_d  = req_i.wdata[6:0];
                    min7_d = req_i.wdata[7];
                end
                `ADR_HOURS: hour_d = req_i.wdata[5:0];
                `ADR_DAYS:  day_d  = req_i.wdata[5:0];
                default: ;
            endcase
        end
        // Hardware events win over a clearing write in the same cycle
        if (alarm_event_i) begin
            ctl_two_d.alarm_flag = 1'b1;
        end
        if (timer_event_i) begin
            ctl_two_d.timer_flag = 1'b1;
        end
        if (supply_low_i) begin
            vl_d = 1'b1;
        end
        if (override_seq_i && int_rst && !rst_i && ctl_one_q[`C1_GATE_BIT]) begin
            ovr_d = 1'b1;
        end
        // Internal reset wins over writes to control, seconds and minutes bit seven; minute, hour and day writes still land; the time counts themselves survive it
        if (int_rst) begin
            ctl_one_d = `C1_RESET;
            ctl_two_d = `C2_RESET;
            vl_d      = 1'b1;
            min7_d    = 1'b1;
            ptr_d     = 4'h0;
            pend_d    = 1'b0;
            sec_d     = sec_q;
        end
    end

    always_comb begin
        int_n_d = 1'b1;
        if (ctl_two_q.alarm_flag && ctl_two_q.alarm_irq_enable) begin
            int_n_d = 1'b0;
        end else if (ctl_two_q.timer_irq_enable) begin
            // Pulse mode marks each timer event with one clock low
            int_n_d = ctl_two_q.irq_pulse_select ? ~timer_event_i : ~ctl_two_q.timer_flag;
        end
    end

    always_ff @(posedge clock_i) begin
        xtal_q                     <= xtal_i;
        clock_output_o             <= xtal_i;
        external_clock_test_mode_o <= ctl_one_q[`C1_TEST_BIT];
        if (rst_i) begin
            ctl_one_q   <= `C1_RESET;
            ctl_two_q   <= `C2_RESET;
            sec_q       <= 7'h00;
            min_q       <= 7'h00;
            hour_q      <= 6'h00;
            day_q       <= `DAY_FIRST;
            vl_q        <= 1'b1;
            min7_q      <= 1'b1;
            ptr_q       <= 4'h0;
            div_q       <= 16'h0000;
            pend_q      <= 1'b0;
            ovr_q       <= 1'b0;
            rdata_o     <= 8'h00;
            int_n_o     <= 1'b1;
            day_carry_o <= 1'b0;
        end else begin
            ctl_one_q   <= ctl_one_d;
            ctl_two_q   <= ctl_two_d;
            sec_q       <= sec_d;
            min_q       <= min_d;
            hour_q      <= hour_d;
            day_q       <= day_d;
            vl_q        <= vl_d;
            min7_q      <= min7_d;
            ptr_q       <= ptr_d;
            div_q       <= div_d;
            pend_q      <= pend_d;
            ovr_q       <= ovr_d;
            rdata_o     <= rdata_d;
            int_n_o     <= int_n_d;
            day_carry_o <= carry_d;
        end
    end

    stop_clears_a: assert property (@(posedge clock_i) disable iff (rst_i)
        ctl_one_q[`C1_STOP_BIT] |=> div_q == 16'h0000 && $stable(sec_q)) else $error("divider runs while stopped");
    gate_reset_a: assert property (@(posedge clock_i) disable iff (rst_i)
        int_rst |=> ctl_one_q == `C1_RESET) else $error("control one not reset");
    alarm_irq_a: assert property (@(posedge clock_i) disable iff (rst_i)
        ctl_two_q.alarm_flag && ctl_two_q.alarm_irq_enable |=> !int_n_o) else $error("alarm irq not held");
    level_irq_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !ctl_two_q.alarm_irq_enable && ctl_two_q.timer_irq_enable && !ctl_two_q.irq_pulse_select
        |=> int_n_o == !$past(ctl_two_q.timer_flag)) else $error("timer level irq wrong");
    ptr_reset_a: assert property (@(posedge clock_i) disable iff (rst_i)
        int_rst |=> ptr_q == 4'h0 && ctl_two_q == `C2_RESET && vl_q) else $error("reset state wrong");
    override_a: assert property (@(posedge clock_i) disable iff (rst_i)
        override_seq_i && int_rst && ctl_one_q[`C1_GATE_BIT] |=> !int_rst) else $error("override ignored");
    gate_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
        req_i.wr && ptr_q == `ADR_CTL_ONE && !req_i.wdata[`C1_GATE_BIT] && !int_rst |=> !ovr_q)
        else $error("override not cancelled");
    vl_sticky_a: assert property (@(posedge clock_i) disable iff (rst_i)
        supply_low_i |=> vl_q ##1 vl_q || $past(req_i.wr)) else $error("supply flag lost");
    sec_wrap_a: assert property (@(posedge clock_i) disable iff (rst_i)
        step && !req_i.wr && sec_q == `SEC_MAX |=> sec_q == 7'h00) else $error("seconds wrap wrong");
    freeze_a: assert property (@(posedge clock_i) disable iff (rst_i)
        tick && access_i && !int_rst |=> pend_q && $stable(sec_q) || $past(req_i.wr)) else $error("tick lost");

    // Calendar and flag checks; all but leap_rule_a, pulse_irq_a, test_out_a, clock_out_a and min_seven_a exempt cycles where a write or reset takes over
    min_wrap_a: assert property (@(posedge clock_i) disable iff (rst_i)
        step && !req_i.wr && sec_q == `SEC_MAX && min_q == `MIN_MAX |=> min_q == 7'h00)
        else $error("minutes wrap wrong");
    hour_wrap_a: assert property (@(posedge clock_i) disable iff (rst_i)
        step && !req_i.wr && sec_q == `SEC_MAX && min_q == `MIN_MAX && hour_q == `HOUR_MAX |=> hour_q == 6'h00)
        else $error("hours wrap wrong");
    day_wrap_a: assert property (@(posedge clock_i) disable iff (rst_i)
        step && !req_i.wr && sec_q == `SEC_MAX && min_q == `MIN_MAX && hour_q == `HOUR_MAX && day_q >= day_max
        |=> day_q == `DAY_FIRST && day_carry_o) else $error("day wrap wrong");
    leap_rule_a: assert property (@(posedge clock_i) disable iff (rst_i)
        leap == ((int'(year_bcd_i[7:4]) * 10 + int'(year_bcd_i[3:0])) % 4 == 0))
        else $error("leap year decode wrong");
    leap_day_a: assert property (@(posedge clock_i) disable iff (rst_i)
        step && !req_i.wr && sec_q == `SEC_MAX && min_q == `MIN_MAX && hour_q == `HOUR_MAX && leap
        && month_bcd_i == `MON_FEB && day_q == `DAY_FEB |=> day_q == `DAY_LEAP) else $error("leap day skipped");
    pulse_irq_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !(ctl_two_q.alarm_flag && ctl_two_q.alarm_irq_enable) && ctl_two_q.timer_irq_enable
        && ctl_two_q.irq_pulse_select && timer_event_i |=> !int_n_o) else $error("timer pulse missing");
    test_out_a: assert property (@(posedge clock_i) disable iff (rst_i)
        external_clock_test_mode_o == $past(ctl_one_q[`C1_TEST_BIT])) else $error("test mode output wrong");
    clock_out_a: assert property (@(posedge clock_i) disable iff (rst_i)
        clock_output_o == $past(xtal_i)) else $error("clock output not following crystal");
    vl_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
        req_i.wr && ptr_q == `ADR_SECONDS && !req_i.wdata[7] && !supply_low_i && !int_rst
        |=> !vl_q) else $error("supply flag not cleared");
    alarm_set_a: assert property (@(posedge clock_i) disable iff (rst_i)
        alarm_event_i && !int_rst |=> ctl_two_q.alarm_flag) else $error("alarm flag not set");
    timer_set_a: assert property (@(posedge clock_i) disable iff (rst_i)
        timer_event_i && !int_rst |=> ctl_two_q.timer_flag) else $error("timer flag not set");
    min_seven_a: assert property (@(posedge clock_i) disable iff (rst_i)
        int_rst |=> min7_q) else $error("minutes bit seven not reset");
    pending_tick_a: assert property (@(posedge clock_i) disable iff (rst_i)
        pend_q && !access_i && !int_rst && !ctl_one_q[`C1_STOP_BIT] && !req_i.wr |=> $changed(sec_q))
        else $error("held tick not serviced");
endmodule

// ### dv/rtc_host.sv
`timescale 1ns/1ps
module rtc_host (
    input  wire logic         clock_i,
    input  wire logic [7:0]   rdata_i,
    output logic              access_o,
    output rtc_pkg::reg_req_t req_o
);
    logic hold;
    initial begin
        access_o = 1'b0;
        req_o = '0;
        hold = 1'b0;
    end
    // Access held through every request so counting stays frozen meanwhile
    task automatic issue(input logic w, input logic r, input logic l, input logic [7:0] d);
        @(posedge clock_i);
        #1;
        access_o = 1'b1;
        req_o = '{wr: w, rd: r, ptr_load: l, wdata: d};
    endtask
    task automatic idle();
        @(posedge clock_i);
        #1;
        req_o = '0;
        access_o = hold;
    endtask
    task automatic put(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] m;
        m = (a == 4'h0) ? 8'hA8 : (a == 4'h1) ? 8'h1F : 8'hFF;
        issue(1'b0, 1'b0, 1'b1, {4'h0, a});
        issue(1'b1, 1'b0, 1'b0, d & m);
        idle();
    endtask
    task automatic get(input logic [3:0] a, output logic [7:0] d);
        issue(1'b0, 1'b0, 1'b1, {4'h0, a});
        issue(1'b0, 1'b1, 1'b0, 8'h00);
        idle();
        d = rdata_i;
    endtask
endmodule

// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clock_i = 1'b0, rst_i = 1'b1, xtal_i = 1'b0, osc_i = 1'b1, ovr_i = 1'b0, low_i = 1'b0;
    logic alarm_i = 1'b0, timer_i = 1'b0, carry_seen = 1'b0;
    logic [4:0] month_i = 5'h02;
    logic [7:0] year_i = 8'h04, v;
    logic access, int_n, clk_out, test_mode, day_carry;
    logic [7:0] rdata;
    rtc_pkg::reg_req_t req;
    int mismatches = 0, n_compared = 0, cycles = 0, lows;
    always #20 clock_i = ~clock_i;
    rtc_core #(.DIV_COUNT(4)) DUT (.clock_i(clock_i), .rst_i(rst_i), .xtal_i(xtal_i), .osc_running_i(osc_i),
        .override_seq_i(ovr_i), .supply_low_i(low_i), .alarm_event_i(alarm_i), .timer_event_i(timer_i),
        .access_i(access), .req_i(req), .month_bcd_i(month_i), .year_bcd_i(year_i), .rdata_o(rdata),
        .int_n_o(int_n), .clock_output_o(clk_out), .external_clock_test_mode_o(test_mode),
        .day_carry_o(day_carry));
    rtc_host host (.clock_i(clock_i), .rdata_i(rdata), .access_o(access), .req_o(req));
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (day_carry === 1'b1) carry_seen <= 1'b1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            report_and_stop();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("Error t=%0t got %h exp %h", $time, got, exp);
            mismatches++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    // Tick count stays aligned because the divider is fed whole seconds except in t_stop, where stop holds it cleared
    task automatic ticks(input int n);
        repeat (n * 4) begin
            cyc(2); xtal_i = 1'b1;
            cyc(2); xtal_i = 1'b0;
        end
        cyc(2);
    endtask
    task automatic t_reset();
        host.get(4'h0, v); chk(v, 8'h08);
        host.get(4'h1, v); chk(v & 8'h1F, 8'h00);
        host.get(4'h2, v); chk(v & 8'h80, 8'h80);
        host.get(4'h3, v); chk(v & 8'h80, 8'h80);
        host.get(4'h6, v); chk(v, 8'h00);
    endtask
    task automatic t_control();
        host.put(4'h0, 8'h88); cyc(1); chk({7'h0, test_mode}, 8'h01);
        host.put(4'h0, 8'h00); cyc(1); chk({7'h0, test_mode}, 8'h00);
        host.get(4'h0, v); chk(v, 8'h00);
        host.put(4'h0, 8'h08);
    endtask
    task automatic t_irq();
        host.put(4'h1, 8'h11);
        timer_i = 1'b1; cyc(1); timer_i = 1'b0;
        lows = 0;
        repeat (8) begin lows += (int_n === 1'b0); cyc(1); end
        chk(lows[7:0], 8'h01);
        host.put(4'h1, 8'h01);
        timer_i = 1'b1; cyc(1); timer_i = 1'b0; cyc(4);
        chk({7'h0, int_n}, 8'h00);
        host.get(4'h1, v); chk(v & 8'h1F, 8'h05);
        host.put(4'h1, 8'h12);
        alarm_i = 1'b1; cyc(1); alarm_i = 1'b0; cyc(6);
        chk({7'h0, int_n}, 8'h00);
        host.get(4'h1, v); chk(v & 8'h1F, 8'h1A);
        host.put(4'h1, 8'h00); cyc(3); chk({7'h0, int_n}, 8'h01);
    endtask
    task automatic t_supply();
        host.put(4'h2, 8'h00); host.get(4'h2, v); chk(v, 8'h00);
        low_i = 1'b1; cyc(2); low_i = 1'b0;
        host.get(4'h2, v); chk(v, 8'h80);
    endtask
    task automatic t_stop();
        host.put(4'h0, 8'h28);
        ticks(2);
        xtal_i = 1'b1; cyc(2); chk({7'h0, clk_out}, 8'h01);
        xtal_i = 1'b0;
        host.get(4'h2, v); chk(v, 8'h80);
        host.put(4'h0, 8'h08);
    endtask
    task automatic set_time();
        host.put(4'h2, 8'h59); host.put(4'h3, 8'h59); host.put(4'h4, 8'h23); host.put(4'h5, 8'h28);
    endtask
    task automatic t_time();
        host.hold = 1'b1;
        set_time(); ticks(2);
        host.hold = 1'b0; host.idle(); cyc(2);
        host.get(4'h2, v); chk(v, 8'h00);
        host.get(4'h3, v); chk(v & 8'h7F, 8'h00);
        host.get(4'h4, v); chk(v & 8'h3F, 8'h00);
        host.get(4'h5, v); chk(v & 8'h3F, 8'h29);
        year_i = 8'h01; set_time(); carry_seen = 1'b0; ticks(1);
        host.get(4'h5, v); chk(v & 8'h3F, 8'h01);
        chk({7'h0, carry_seen}, 8'h01);
    endtask
    task automatic t_por();
        osc_i = 1'b0; cyc(2);
        host.put(4'h0, 8'h88); host.get(4'h0, v); chk(v, 8'h08);
        ovr_i = 1'b1; cyc(1); ovr_i = 1'b0;
        host.put(4'h0, 8'h88); cyc(1); chk({7'h0, test_mode}, 8'h01);
        host.put(4'h0, 8'h80); cyc(2);
        host.get(4'h0, v); chk(v, 8'h08);
        osc_i = 1'b1; cyc(2);
        host.put(4'h0, 8'h08);
    endtask
    initial begin
        cyc(10); rst_i = 1'b0; cyc(1);
        t_reset(); t_control(); t_irq(); t_supply(); t_stop(); t_time(); t_por();
        report_and_stop();
    end
endmodule
